// ==== boie_bit_mask.v ====
`include "boie_defines.vh"

module boie_bit_mask (
  // Bit position
  input  wire [`BOIE_BIT_W-1:0] bit_sel,
  // One-hot mask
  output wire [`BOIE_DAT_W-1:0] mask
);

  genvar i;

  // One decoder line per bit
  generate
    for (i = 0; i < `BOIE_DAT_W; i = i + 1) begin : g_mask
      localparam [`BOIE_BIT_W-1:0] POS = i;
      assign mask[i] = (bit_sel == POS);
    end
  endgenerate

endmodule

// ==== boie_defines.vh ====
`ifndef BOIE_DEFINES_VH
`define BOIE_DEFINES_VH

// Instruction word layout
`define BOIE_IW_W        14
`define BOIE_CLASS_HI    13
`define BOIE_CLASS_LO    12
`define BOIE_SUB_HI      11
`define BOIE_SUB_LO      10
`define BOIE_BIT_HI      9
`define BOIE_BIT_LO      7
`define BOIE_ADR_HI      6
`define BOIE_ADR_LO      0
`define BOIE_ADR_W       7
`define BOIE_BIT_W       3
`define BOIE_DAT_W       8

// Opcode values
`define BOIE_CLASS_BIT   2'h1
`define BOIE_SUB_CLR     2'h0
`define BOIE_SUB_SET     2'h1
`define BOIE_SUB_TSTZ    2'h2

// Reset values
`define BOIE_ADR_RST     7'h00
`define BOIE_DAT_RST     8'h00
`define BOIE_IW_RST      14'h0000

`endif

// ==== boie_exec.v ====
`include "boie_defines.vh"

module boie_exec (
  // Clock and control
  input  wire                   sys_clk,
  input  wire                   rst_n,
  input  wire                   clk_en,
  // Instruction from fetch
  input  wire [`BOIE_IW_W-1:0]  instr,
  input  wire                   instr_valid,
  // Register file read port
  output wire [`BOIE_ADR_W-1:0] rf_raddr,
  input  wire [`BOIE_DAT_W-1:0] rf_rdata,
  // Register file write port
  output reg                    rf_we_r,
  output reg  [`BOIE_ADR_W-1:0] rf_waddr_r,
  output reg  [`BOIE_DAT_W-1:0] rf_wdata_r,
  // Pipeline status
  output reg                    skip_r,
  output reg                    nop_exec_r,
  output reg                    bit_op_r
);

  // Timing of one accepted word:
  //   edge 0 takes the word, read data is combinational
  //   edge 0 also loads the write strobe, address and data
  //   a zero test loads skip_r and enters the skip slot
  //   edge 1 drops the prefetched word and pulses nop_exec_r
  //   clk_en low holds every register, pulses included

  // Local states, one-hot
  localparam ST_RUN  = 2'b01;
  localparam ST_SKIP = 2'b10;

  // Sequencer state
  reg  [1:0]             state_r;
  reg  [1:0]             state_nxt;

  // Next values of the registered outputs
  reg                    we_nxt;
  reg  [`BOIE_DAT_W-1:0] wdata_nxt;
  reg                    skip_nxt;
  reg                    nop_nxt;
  reg                    bit_op_nxt;

  // Instruction fields
  wire [1:0]             op_class;
  wire [1:0]             op_sub;
  wire [`BOIE_BIT_W-1:0] bit_pos;
  wire [`BOIE_ADR_W-1:0] file_adr;

  // Decoded operation and selected bit
  wire [`BOIE_DAT_W-1:0] mask;
  wire [`BOIE_DAT_W-1:0] clr_data;
  wire [`BOIE_DAT_W-1:0] set_data;
  wire                   is_bit;
  wire                   op_clr;
  wire                   op_set;
  wire                   op_tstz;
  wire                   in_run;
  wire                   accept;
  wire                   op_wr;
  wire                   take_skip;
  wire                   sel_bit;

  // Field split
  assign op_class = instr[`BOIE_CLASS_HI:`BOIE_CLASS_LO];
  assign op_sub   = instr[`BOIE_SUB_HI:`BOIE_SUB_LO];
  assign bit_pos  = instr[`BOIE_BIT_HI:`BOIE_BIT_LO];
  assign file_adr = instr[`BOIE_ADR_HI:`BOIE_ADR_LO];

  // Opcode decode
  assign is_bit  = (op_class == `BOIE_CLASS_BIT);
  assign op_clr  = is_bit && (op_sub == `BOIE_SUB_CLR);
  assign op_set  = is_bit && (op_sub == `BOIE_SUB_SET);
  assign op_tstz = is_bit && (op_sub == `BOIE_SUB_TSTZ);

  // Prefetched word in the skip slot is never accepted
  assign in_run = (state_r == ST_RUN);
  assign accept = instr_valid && in_run;

  // Async read port follows the address field
  assign rf_raddr = file_adr;
  assign sel_bit  = |(rf_rdata & mask);

  // Write and skip qualifiers
  assign op_wr     = accept && (op_clr || op_set);
  assign take_skip = accept && op_tstz && !sel_bit;

  // Bit position to one-hot mask
  boie_bit_mask u_mask (
    .bit_sel (bit_pos),
    .mask    (mask)
  );

  // Per-bit modify: only the selected bit may change
  genvar k;
  generate
    for (k = 0; k < `BOIE_DAT_W; k = k + 1) begin : g_mod
      assign clr_data[k] = mask[k] ? 1'b0 : rf_rdata[k];
      assign set_data[k] = mask[k] ? 1'b1 : rf_rdata[k];
    end
  endgenerate

  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (take_skip) begin
          state_nxt = ST_SKIP;
        end
      end
      ST_SKIP: begin
        // Prefetched word dropped, no-op cycle
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // Write path: full-byte read-modify-write
  always @* begin
    we_nxt    = 1'b0;
    wdata_nxt = rf_rdata;
    if (op_wr) begin
      we_nxt = 1'b1;
      if (op_clr) begin
        wdata_nxt = clr_data;
      end else begin
        wdata_nxt = set_data;
      end
    end
  end

  // Skip, no-op slot and accepted-op pulses
  always @* begin
    skip_nxt   = 1'b0;
    nop_nxt    = 1'b0;
    bit_op_nxt = 1'b0;
    if (state_r == ST_SKIP) begin
      nop_nxt = 1'b1;
    end
    if (accept) begin
      bit_op_nxt = op_clr || op_set || op_tstz;
      if (take_skip) begin
        skip_nxt = 1'b1;
      end
    end
  end

  // Sequencer state register
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Write strobe
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rf_we_r <= 1'b0;
    end else if (clk_en) begin
      rf_we_r <= we_nxt;
    end
  end

  // Write address
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rf_waddr_r <= `BOIE_ADR_RST;
    end else if (clk_en) begin
      rf_waddr_r <= file_adr;
    end
  end

  // Write data
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rf_wdata_r <= `BOIE_DAT_RST;
    end else if (clk_en) begin
      rf_wdata_r <= wdata_nxt;
    end
  end

  // Skip taken pulse
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      skip_r <= 1'b0;
    end else if (clk_en) begin
      skip_r <= skip_nxt;
    end
  end

  // No-op slot pulse
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      nop_exec_r <= 1'b0;
    end else if (clk_en) begin
      nop_exec_r <= nop_nxt;
    end
  end

  // Accepted bit op pulse
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      bit_op_r <= 1'b0;
    end else if (clk_en) begin
      bit_op_r <= bit_op_nxt;
    end
  end

endmodule

// ==== boie_monitor.sv ====
module boie_monitor (
  input wire        sys_clk, rst_n, clk_en, instr_valid,
  input wire        rf_we_r, skip_r, nop_exec_r, bit_op_r,
  input wire [13:0] instr,
  input wire [6:0]  rf_raddr, rf_waddr_r,
  input wire [7:0]  rf_rdata, rf_wdata_r
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Accepted bit op, its mask and a zero test
  wire [7:0] m = 8'h01 << instr[9:7];
  wire       t = clk_en && instr_valid && !skip_r && instr[13:12] == 2'h1;
  wire       z = !(|(rf_rdata & m));
  sequence skip_s; t && instr[11:10] == 2'h2 && z; endsequence
  clr_write_a: assert property (t && instr[11:10] == 2'h0 |=> rf_we_r &&
    rf_wdata_r == ($past(rf_rdata) & ~$past(m)) && rf_waddr_r == $past(instr[6:0]))
    else $error("clear write wrong");
  set_write_a: assert property (t && instr[11:10] == 2'h1 |=> rf_we_r &&
    rf_wdata_r == ($past(rf_rdata) | $past(m))) else $error("set write wrong");
  read_addr_a: assert property (rf_raddr == instr[6:0]) else $error("bad read address");
  test_skip_a: assert property (t && instr[11:10] == 2'h2 |=>
    !rf_we_r && bit_op_r && skip_r == $past(z)) else $error("test skip wrong");
  skip_nop_a: assert property (skip_s ##1 clk_en |=> nop_exec_r)
    else $error("no nop after skip");
  slot_drop_a: assert property (skip_r && clk_en |=> !rf_we_r && !bit_op_r)
    else $error("discarded word ran");
endmodule
bind boie_exec boie_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .instr_valid(instr_valid), .rf_we_r(rf_we_r), .skip_r(skip_r), .nop_exec_r(nop_exec_r),
  .bit_op_r(bit_op_r), .instr(instr), .rf_raddr(rf_raddr), .rf_waddr_r(rf_waddr_r),
  .rf_rdata(rf_rdata), .rf_wdata_r(rf_wdata_r));

// ==== boie_rf_model.sv ====
module boie_rf_model (
  input wire       sys_clk, rf_we_r,
  input wire [6:0] rf_raddr, rf_waddr_r,
  input wire [7:0] rf_wdata_r,
  output wire [7:0] rf_rdata
);
  timeunit 1ns; timeprecision 1ps;
  logic [7:0] mem [128];
  // Seeded contents, async read, clocked write
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  assign rf_rdata = mem[rf_raddr];
  always @(posedge sys_clk) if (rf_we_r) mem[rf_waddr_r] <= rf_wdata_r;
endmodule

// ==== testbench.sv ====
module testbench;
  timeunit 1ns; timeprecision 1ps;
  logic sys_clk = 0, rst_n = 0, instr_valid = 0, rf_we_r, skip_r, nop_exec_r, bit_op_r;
  logic clk_en = 1;
  logic [13:0] instr = 14'h0000;
  logic [6:0] rf_raddr, rf_waddr_r;
  logic [7:0] rf_rdata, rf_wdata_r, v;
  int error_cnt = 0, comparisons = 0;
  always #12.5 sys_clk = ~sys_clk;
  boie_exec dut (.sys_clk, .rst_n, .clk_en, .instr, .instr_valid, .rf_raddr,
    .rf_rdata, .rf_we_r, .rf_waddr_r, .rf_wdata_r, .skip_r, .nop_exec_r, .bit_op_r);
  boie_rf_model rf (.sys_clk, .rf_we_r, .rf_raddr, .rf_waddr_r, .rf_wdata_r, .rf_rdata);
  task chk(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  // One instruction word per cycle, then idle cycles
  task put(input [1:0] o, input [2:0] b, input [6:0] f);
    @(posedge sys_clk); #1 instr = {2'h1, o, b, f}; instr_valid = 1;
  endtask
  task idle(input int n);
    repeat (n) begin @(posedge sys_clk); #1 instr_valid = 0; end
  endtask
  task t_clr_set;
    v = rf.mem[127];
    put(2'h0, 3'h3, 7'h7f); put(2'h1, 3'h0, 7'h00); idle(3);
    chk("clr", rf.mem[127], v & 8'hf7);
    chk("set", rf.mem[0], 8'h01);
  endtask
  task t_skip;
    put(2'h2, 3'h7, 7'h00); put(2'h1, 3'h7, 7'h00);
    chk("skip", 8'(skip_r), 8'h01);
    chk("test op", 8'(bit_op_r), 8'h01);
    idle(1); chk("nop", 8'(nop_exec_r), 8'h01);
    chk("slot op", 8'(bit_op_r), 8'h00);
    idle(2); chk("slot", rf.mem[0], 8'h01);
  endtask
  task t_noskip;
    put(2'h2, 3'h0, 7'h00); put(2'h1, 3'h1, 7'h00);
    chk("noskip", 8'(skip_r), 8'h00);
    chk("noskip op", 8'(bit_op_r), 8'h01);
    idle(3); chk("run", rf.mem[0], 8'h03);
  endtask
  // Reset in the middle of a skip clears the pending slot
  task t_reset;
    put(2'h2, 3'h7, 7'h00);
    @(posedge sys_clk); #1 instr_valid = 0; rst_n = 0;
    chk("skip before reset", 8'(skip_r), 8'h01);
    @(posedge sys_clk); #1 rst_n = 1;
    chk("skip in reset", 8'(skip_r), 8'h00);
    chk("op in reset", 8'(bit_op_r), 8'h00);
    idle(1); chk("slot after reset", 8'(nop_exec_r), 8'h00);
  endtask
  // Clock enable low holds off a set
  task t_freeze;
    v = rf.mem[0];
    @(posedge sys_clk); #1 clk_en = 0; instr = {2'h1, 2'h1, 3'h2, 7'h00}; instr_valid = 1;
    repeat (2) @(posedge sys_clk);
    #1 instr_valid = 0;
    chk("frozen write", rf.mem[0], v);
    chk("frozen op", 8'(bit_op_r), 8'h00);
    clk_en = 1; idle(2);
    chk("after thaw", rf.mem[0], v);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1;
    chk("we after reset", 8'(rf_we_r), 8'h00);
    chk("skip after reset", 8'(skip_r), 8'h00);
    t_clr_set; t_skip; t_noskip; t_reset; t_freeze; print_verdict;
  end
endmodule
